// *** verilog/dic_conditioner.sv ***
`timescale 1ns/1ps
// Behaviour
// - profile one samples every 2-10 ms
// - profile two has own 2-10 ms period
// - profile one validates after 1-10 equal samples
// - profile two validates after 2-10 equal samples
// - each input selects its filter profile
// - too many changes in slot freezes input
// - frozen input re-enabled by rule or command
// - re-enable uses own slot and count
// - auto disable only when input setting yes
// - low supply clears all validation signals
// - validation restored when supply above threshold
// - element enable from buttons, input, command
// - unconfigured element enable defaults to one
// - out of service element outputs held inactive
// - periods step 2 ms, default 6 ms
// - defaults: enable 5, disable 60, slots 2 s
module dic_conditioner
    import dic_pkg::*;
#(
    parameter int NUM_INPUTS = 8,
    parameter int NUM_ELEMENTS = 4,
    parameter int NUM_ELEM_OUTS = 4,
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [NUM_INPUTS-1:0] physical_status_input,
    input wire logic [NUM_INPUTS-1:0] profileSel,
    input wire logic [NUM_INPUTS-1:0] autoDisable,
    input wire logic [NUM_INPUTS-1:0] enableCmd,
    input wire logic [3:0] period1Ms,
    input wire logic [3:0] period2Ms,
    input wire logic [3:0] valid1Count,
    input wire logic [3:0] valid2Count,
    input wire logic [5:0] disableChanges,
    input wire logic [4:0] disableSlotS,
    input wire logic [5:0] enableChanges,
    input wire logic [4:0] enableSlotS,
    input wire logic cfgLoad,
    input wire logic supplyControl,
    input wire logic supplyAboveThreshold,
    input wire logic [NUM_ELEMENTS-1:0] enableButton,
    input wire logic [NUM_ELEMENTS-1:0] enableViaInput,
    input wire logic [NUM_ELEMENTS-1:0] enableViaComms,
    input wire logic [NUM_ELEMENTS-1:0] enableConfigured,
    input wire logic [NUM_ELEMENTS-1:0] inService,
    input wire logic [NUM_ELEMENTS*NUM_ELEM_OUTS-1:0] elementRawOut,
    output logic [NUM_INPUTS-1:0] validLevel,
    output logic [NUM_INPUTS-1:0] validFlag,
    output logic [NUM_ELEMENTS-1:0] elementActive,
    output logic [NUM_ELEMENTS*NUM_ELEM_OUTS-1:0] elementOut
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NUM_INPUTS-1:0] pinMeta;
        logic [NUM_INPUTS-1:0] pinSync;
        logic supMeta;
        logic supSync;
        logic [16:0] msDiv;
        logic msTick;
        logic [9:0] sDiv;
        logic secTick;
        logic [3:0] ms1;
        logic [3:0] ms2;
        logic tick1;
        logic tick2;
        dic_cfg_t cfg;
        logic [NUM_ELEMENTS-1:0] active;
        logic [NUM_ELEMENTS*NUM_ELEM_OUTS-1:0] outs;
    } dic_top_t;

    dic_top_t cur, next_cur;

    function automatic logic [3:0] clampPeriod(input logic [3:0] p);
        logic [3:0] r;
        r = {p[3:1], 1'b0};
        if (r < PERIOD_MIN_MS) r = PERIOD_MIN_MS;
        if (r > PERIOD_MAX_MS) r = PERIOD_MAX_MS;
        return r;
    endfunction : clampPeriod

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_cur = cur;
        next_cur.pinMeta = physical_status_input;
        next_cur.pinSync = cur.pinMeta;
        next_cur.supMeta = supplyAboveThreshold;
        next_cur.supSync = cur.supMeta;
        next_cur.msTick = 1'b0;
        next_cur.secTick = 1'b0;
        next_cur.tick1 = 1'b0;
        next_cur.tick2 = 1'b0;
        if (cur.msDiv == 17'(CYCLES_PER_MS - 1)) begin
            next_cur.msDiv = '0;
            next_cur.msTick = 1'b1;
        end else begin
            next_cur.msDiv = cur.msDiv + 17'h1;
        end
        if (cur.msTick) begin
            next_cur.sDiv = (cur.sDiv == 10'(MS_PER_S - 1)) ? 10'h0 : cur.sDiv + 10'h1;
            next_cur.secTick = (cur.sDiv == 10'(MS_PER_S - 1));
            next_cur.ms1 = cur.ms1 + 4'h1;
            next_cur.ms2 = cur.ms2 + 4'h1;
            if (cur.ms1 + 4'h1 >= clampPeriod(cur.cfg.period1Ms)) begin
                next_cur.ms1 = '0;
                next_cur.tick1 = 1'b1;
            end
            if (cur.ms2 + 4'h1 >= clampPeriod(cur.cfg.period2Ms)) begin
                next_cur.ms2 = '0;
                next_cur.tick2 = 1'b1;
            end
        end
        if (cfgLoad) begin
            next_cur.cfg = '{period1Ms, period2Ms, valid1Count, valid2Count,
                disableChanges, disableSlotS, enableChanges, enableSlotS, supplyControl};
        end
        for (int e = 0; e < NUM_ELEMENTS; e++) begin
            next_cur.active[e] = (!enableConfigured[e] ||
                enableButton[e] || enableViaInput[e] || enableViaComms[e]) && inService[e];
            for (int k = 0; k < NUM_ELEM_OUTS; k++) begin
                next_cur.outs[e*NUM_ELEM_OUTS+k] = elementRawOut[e*NUM_ELEM_OUTS+k] && next_cur.active[e];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cur <= '0;
            cur.cfg <= '{PERIOD_RST_MS, PERIOD_RST_MS, VAL_RST, VAL_RST,
                DIS_CNT_RST, SLOT_RST_S, ENA_CNT_RST, SLOT_RST_S, 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_ch
        dic_channel u_ch (
            .core_clk(core_clk),
            .reset(reset),
            .tick1(cur.tick1),
            .tick2(cur.tick2),
            .secTick(cur.secTick),
            .rawLevel(cur.pinSync[i]),
            .profileSel(profileSel[i]),
            .autoDisable(autoDisable[i]),
            .enableCmd(enableCmd[i]),
            .supplyLow(!cur.supSync),
            .cfg(cur.cfg),
            .validLevel(validLevel[i]),
            .validFlag(validFlag[i])
        );
    end

    assign elementActive = cur.active;
    assign elementOut = cur.outs;

    ////////////////////////////////////////////////////////////////////////////
    sequence ms_edge_s;
        cur.msTick;
    endsequence

    tick_only_ms_a: assert property (@(posedge core_clk) disable iff (reset)
        (cur.tick1 || cur.tick2) |-> $past(cur.msTick))
        else $error("sample tick without ms tick");
    ms_spacing_a: assert property (@(posedge core_clk) disable iff (reset)
        ms_edge_s |=> !cur.msTick [*8])
        else $error("ms ticks too close");
    elem_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        !inService[0] |=> !elementActive[0] && elementOut[NUM_ELEM_OUTS-1:0] == '0)
        else $error("out of service element active");
    elem_default_a: assert property (@(posedge core_clk) disable iff (reset)
        !enableConfigured[0] && inService[0] |=> elementActive[0])
        else $error("unconfigured enable not one");
endmodule : dic_conditioner

// *** shared/dic_pkg.sv ***
package dic_pkg;
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_STEP_MS = 2;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int MS_PER_S = 1000;
    localparam logic [3:0] PERIOD_RST_MS = 4'h6;
    localparam logic [3:0] PERIOD_MIN_MS = 4'h2;
    localparam logic [3:0] PERIOD_MAX_MS = 4'ha;
    localparam logic [3:0] VAL1_MIN = 4'h1;
    localparam logic [3:0] VAL2_MIN = 4'h2;
    localparam logic [3:0] VAL_MAX = 4'ha;
    localparam logic [3:0] VAL_RST = 4'h2;
    localparam logic [5:0] DIS_CNT_RST = 6'h3c;
    localparam logic [5:0] ENA_CNT_RST = 6'h05;
    localparam logic [4:0] SLOT_RST_S = 5'h02;
    localparam logic [4:0] SLOT_MAX_S = 5'h1e;
    localparam logic [4:0] SLOT_MIN_S = 5'h01;
    localparam logic [5:0] CHG_MIN = 6'h02;

    typedef struct packed {
        logic [3:0] period1Ms;
        logic [3:0] period2Ms;
        logic [3:0] valid1Count;
        logic [3:0] valid2Count;
        logic [5:0] disableChanges;
        logic [4:0] disableSlotS;
        logic [5:0] enableChanges;
        logic [4:0] enableSlotS;
        logic supplyControl;
    } dic_cfg_t;

    typedef enum logic [1:0] {
        CH_RUN = 2'b01,
        CH_FROZEN = 2'b10
    } dic_chan_state_t;
endpackage : dic_pkg

// *** verilog/dic_channel.sv ***
`timescale 1ns/1ps
module dic_channel
    import dic_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tick1,
    input wire logic tick2,
    input wire logic secTick,
    input wire logic rawLevel,
    input wire logic profileSel,
    input wire logic autoDisable,
    input wire logic enableCmd,
    input wire logic supplyLow,
    input wire dic_cfg_t cfg,
    output logic validLevel,
    output logic validFlag
);
    typedef struct packed {
        logic level;
        logic filt;
        logic lastSample;
        logic [3:0] run;
        logic [5:0] changes;
        logic [4:0] slotS;
        dic_chan_state_t st;
    } dic_ch_t;

    dic_ch_t cur, next_cur;
    logic tick;
    logic [3:0] need;
    logic [5:0] limit;
    logic [4:0] slotLen;
    logic bump;

    always_comb begin
        next_cur = cur;
        tick = profileSel ? tick2 : tick1;
        need = profileSel ? cfg.valid2Count : cfg.valid1Count;
        if (!profileSel && need < VAL1_MIN) need = VAL1_MIN;
        if (profileSel && need < VAL2_MIN) need = VAL2_MIN;
        if (need > VAL_MAX) need = VAL_MAX;
        limit = (cur.st == CH_RUN) ? cfg.disableChanges : cfg.enableChanges;
        if (limit < CHG_MIN) limit = CHG_MIN;
        slotLen = (cur.st == CH_RUN) ? cfg.disableSlotS : cfg.enableSlotS;
        if (slotLen < SLOT_MIN_S) slotLen = SLOT_MIN_S;
        if (slotLen > SLOT_MAX_S) slotLen = SLOT_MAX_S;
        bump = 1'b0;
        if (tick) begin
            next_cur.lastSample = rawLevel;
            if (rawLevel != cur.lastSample) begin
                next_cur.run = 4'h1;
            end else if (cur.run < need) begin
                next_cur.run = cur.run + 4'h1;
            end
            if ((rawLevel == cur.lastSample ? cur.run + 4'h1 : 4'h1) >= need && rawLevel != cur.filt) begin
                next_cur.filt = rawLevel;
                bump = 1'b1;
            end
        end
        // filtered level keeps tracking while frozen so changes are counted once each
        if (bump && cur.changes != 6'h3f) next_cur.changes = cur.changes + 6'h01;
        if (cur.st == CH_RUN) next_cur.level = next_cur.filt;
        if (secTick) begin
            if (cur.slotS + 5'h01 >= slotLen) begin
                next_cur.slotS = '0;
                next_cur.changes = {5'h00, bump};
                if (cur.st == CH_FROZEN && cur.changes < limit) next_cur.st = CH_RUN;
            end else begin
                next_cur.slotS = cur.slotS + 5'h01;
            end
        end
        if (cur.st == CH_RUN && autoDisable && next_cur.changes > limit) begin
            next_cur.st = CH_FROZEN;
            next_cur.changes = '0;
            next_cur.slotS = '0;
        end
        if (cur.st == CH_FROZEN) begin
            case (enableCmd)
                1'b1: begin
                    next_cur.st = CH_RUN;
                    next_cur.changes = '0;
                    next_cur.slotS = '0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cur <= '{level: 1'b0, filt: 1'b0, lastSample: 1'b0, run: 4'h0, changes: 6'h00, slotS: 5'h00,
                st: CH_RUN};
            validLevel <= 1'b0;
            validFlag <= 1'b0;
        end else begin
            cur <= next_cur;
            validLevel <= (supplyLow && cfg.supplyControl) ? 1'b0 : next_cur.level;
            validFlag <= !(supplyLow && cfg.supplyControl) && next_cur.st == CH_RUN;
        end
    end

    frozen_holds_a: assert property (@(posedge core_clk) disable iff (reset)
        cur.st == CH_FROZEN && next_cur.st == CH_FROZEN |-> next_cur.level == cur.level)
        else $error("frozen input changed level");
    no_auto_a: assert property (@(posedge core_clk) disable iff (reset)
        !autoDisable && cur.st == CH_RUN |=> cur.st == CH_RUN)
        else $error("input frozen without auto disable");
    cmd_enable_a: assert property (@(posedge core_clk) disable iff (reset)
        cur.st == CH_FROZEN && enableCmd |=> cur.st == CH_RUN)
        else $error("enable command ignored");
    supply_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        supplyLow && cfg.supplyControl |=> !validFlag && !validLevel)
        else $error("validation not cleared on low supply");
endmodule : dic_channel

// *** verif/dic_field_model.sv ***
`timescale 1ns/1ps
module dic_field_model
    import dic_pkg::*;
#(
    parameter int N = 4,
    parameter int E = 2
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [N-1:0] level,
    input wire logic [N-1:0] chatter,
    input wire logic [N-1:0] validLevel,
    output logic [N-1:0] contact,
    output logic [E-1:0] enableViaInput
);
    logic [6:0] tmr;
    //////////////////////////////////////////////////////////////////////
    // contacts follow the commanded level, chattering ones flip every 100 cycles
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tmr <= 7'h00;
            contact <= '0;
        end else begin
            tmr <= (tmr == 7'h63) ? 7'h00 : tmr + 7'h01;
            contact <= (level & ~chatter) | (((tmr == 7'h63) ? ~contact : contact) & chatter);
        end
    end
    //////////////////////////////////////////////////////////////////////
    // each element enable taken from exactly one validated input
    assign enableViaInput = validLevel[E-1:0];
endmodule : dic_field_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    import dic_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] lvl = 4'h0, chat = 4'h0, prof = 4'h2, autoDis = 4'h4, eCmd = 4'h0;
    logic [3:0] p1 = 4'h2, p2 = 4'ha, v1 = 4'h3, v2 = 4'ha;
    logic [5:0] disCh = 6'h02, enaCh = 6'h02;
    logic [4:0] disSl = 5'h01, enaSl = 5'h01;
    logic cfgLoad = 1'b0, supCtl = 1'b0, supOk = 1'b1;
    logic [1:0] btn = 2'h0, comms = 2'h0, eCfg = 2'h0, inSvc = 2'h0;
    logic [3:0] rawOut = 4'hf;
    logic [3:0] contact, validLevel, validFlag, eOut;
    logic [1:0] eAct, eViaIn;
    logic keep;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    dic_conditioner #(.NUM_INPUTS(4), .NUM_ELEMENTS(2), .NUM_ELEM_OUTS(2), .CYCLES_PER_MS(10)) dut (
        .core_clk(core_clk), .reset(reset), .physical_status_input(contact), .profileSel(prof),
        .autoDisable(autoDis), .enableCmd(eCmd), .period1Ms(p1), .period2Ms(p2), .valid1Count(v1),
        .valid2Count(v2), .disableChanges(disCh), .disableSlotS(disSl), .enableChanges(enaCh),
        .enableSlotS(enaSl), .cfgLoad(cfgLoad), .supplyControl(supCtl), .supplyAboveThreshold(supOk),
        .enableButton(btn), .enableViaInput(eViaIn), .enableViaComms(comms), .enableConfigured(eCfg),
        .inService(inSvc), .elementRawOut(rawOut), .validLevel(validLevel), .validFlag(validFlag),
        .elementActive(eAct), .elementOut(eOut));
    dic_field_model #(.N(4), .E(2)) field (.core_clk(core_clk), .reset(reset), .level(lvl),
        .chatter(chat), .validLevel(validLevel), .contact(contact), .enableViaInput(eViaIn));
    //////////////////////////////////////////////////////////////////////
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            end_sim();
        end
    end
    //////////////////////////////////////////////////////////////////////
    task end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_cyc
    task wait_flag(input int i, input logic e, input int mx);
        int k;
        for (k = 0; k < mx && validFlag[i] !== e; k++) @(negedge core_clk);
    endtask : wait_flag
    task load_cfg();
        cfgLoad = 1'b1;
        wait_cyc(1);
        cfgLoad = 1'b0;
    endtask : load_cfg
    task elem(input logic [1:0] s, input logic [1:0] c, input logic [1:0] b, input logic [1:0] m,
              input logic [1:0] x);
        inSvc = s;
        eCfg = c;
        btn = b;
        comms = m;
        wait_cyc(2);
        `CHK("elementActive", x, eAct)
        `CHK("elementOut", {{2{x[1]}}, {2{x[0]}}} & rawOut, eOut)
    endtask : elem
    //////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(10);
        reset = 1'b0;
        lvl = 4'h1;
        wait_cyc(55);
        `CHK("default early", 1'b0, validLevel[0])
        wait_cyc(75);
        `CHK("default valid", 2'b11, {validFlag[0], validLevel[0]})
        elem(2'h3, 2'h0, 2'h0, 2'h0, 2'h3);
        elem(2'h3, 2'h3, 2'h0, 2'h0, 2'h1);
        rawOut = 4'h6;
        elem(2'h3, 2'h3, 2'h2, 2'h0, 2'h3);
        elem(2'h3, 2'h3, 2'h0, 2'h2, 2'h3);
        elem(2'h0, 2'h3, 2'h3, 2'h3, 2'h0);
        lvl = 4'h0;
        wait_cyc(300);
        load_cfg();
        lvl = 4'h3;
        wait_cyc(35);
        `CHK("profile1 early", 2'b00, validLevel[1:0])
        wait_cyc(35);
        `CHK("profile1 valid", 2'b01, validLevel[1:0])
        wait_cyc(840);
        `CHK("profile2 early", 1'b0, validLevel[1])
        wait_cyc(110);
        `CHK("profile2 valid", 1'b1, validLevel[1])
        chat = 4'hc;
        wait_cyc(1000);
        `CHK("chatter freeze", 2'b10, validFlag[3:2])
        keep = validLevel[2];
        wait_cyc(150);
        `CHK("frozen level", keep, validLevel[2])
        chat = 4'h0;
        eCmd = 4'h4;
        wait_cyc(3);
        eCmd = 4'h0;
        `CHK("command enable", 1'b1, validFlag[2])
        chat = 4'hc;
        autoDis = 4'hc;
        wait_cyc(1000);
        `CHK("refreeze", 2'b00, validFlag[3:2])
        chat = 4'h0;
        wait_flag(2, 1'b1, 25000);
        `CHK("auto enable", 2'b11, validFlag[3:2])
        supCtl = 1'b1;
        p1 = 4'h5;
        p2 = 4'h2;
        v1 = 4'h0;
        v2 = 4'h1;
        disCh = 6'h3c;
        enaCh = 6'h05;
        disSl = 5'h02;
        enaSl = 5'h02;
        load_cfg();
        supOk = 1'b0;
        wait_cyc(5);
        `CHK("supply low", 8'h00, {validFlag, validLevel})
        supOk = 1'b1;
        wait_flag(1, 1'b1, 2000);
        `CHK("supply back", 4'hf, {validFlag[1:0], validLevel[1:0]})
        lvl = 4'h0;
        wait_cyc(50);
        `CHK("clamped fast", 2'b00, validLevel[1:0])
        end_sim();
    end
endmodule : tb
